// File: dv/host_pin_model.sv
// Purpose: Host side of the control pins: flag pull-ups and wake-up quiet time
// Assumes: 40 MHz clk_i; both flags are open-drain lines with a pull-up
// Notes:   Quiet time is counted in clk_i cycles, 10 us by default
`timescale 1ns/1ps
`default_nettype none
module host_pin_model #(
   parameter int unsigned QUIET_CYC = 400
) (
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic rstn_i,
   // Pins seen by the host
   input  wire logic low_power_control_i,
   input  wire logic fault_data_i,
   input  wire logic fault_oe_n_i,
   input  wire logic warn_data_i,
   input  wire logic warn_oe_n_i,
   // Resolved pins and wake-up state
   output logic      fault_pin_o,
   output logic      warn_pin_o,
   output logic      quiet_o
);
   logic [8:0] quiet_cnt_reg;
   logic       low_power_control_reg;
   // Released line floats up to the pull-up level
   assign fault_pin_o = fault_oe_n_i ? 1'b1 : fault_data_i;
   assign warn_pin_o  = warn_oe_n_i ? 1'b1 : warn_data_i;
   assign quiet_o     = (quiet_cnt_reg != 9'h000);
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         quiet_cnt_reg <= 9'h000;
         low_power_control_reg      <= 1'b0;
      end else begin
         low_power_control_reg <= low_power_control_i;
         if (low_power_control_i && !low_power_control_reg) begin
            quiet_cnt_reg <= 9'(QUIET_CYC);
         end else if (quiet_cnt_reg != 9'h000) begin
            quiet_cnt_reg <= quiet_cnt_reg - 9'h001;
         end
      end
   end
endmodule
`default_nettype wire

// File: dv/stepper_brake_standby_fault_tb_top.sv
// Purpose: Self-checking bench of the brake, standby, fault and off-time logic
// Assumes: Inputs change on the rising edge, outputs sampled on the falling edge
// Notes:   Switch vector is {a_pos, a_neg, b_pos, b_neg}
`timescale 1ns/1ps
`default_nettype none
module stepper_brake_standby_fault_tb_top;
   logic       clk_i = 1'b0;
   logic       rstn_i = 1'b0;
   logic       brake_i = 1'b0, low_power_control_i = 1'b0, regulation_off_i = 1'b0;
   logic       phase_a_i = 1'b1, enable_a_i = 1'b1, phase_b_i = 1'b0, enable_b_i = 1'b1;
   logic [stepper_ctrl_pkg::TRQ_W-1:0] torque_i = 4'h5;
   logic       ovc_i = 1'b0, tsd_i = 1'b0, warn_i = 1'b0, restart_i = 1'b0;
   logic       a_pos, a_neg, b_pos, b_neg, reg_on, bias, osc;
   logic       f_d, f_oe_n, w_d, w_oe_n, fault_pin, warn_pin, quiet;
   logic [3:0] cur, sw;
   int         fails = 0;
   int         tests_run = 0;
   int         cnt;
   logic       both_on;
   assign sw = {a_pos, a_neg, b_pos, b_neg};
   always #12.5 clk_i = ~clk_i;
   stepper_brake_standby_fault dut_u (.clk_i(clk_i), .rstn_i(rstn_i), .brake_i(brake_i),
      .low_power_control_i(low_power_control_i), .regulation_off_i(regulation_off_i),
      .phase_a_i(phase_a_i), .enable_a_i(enable_a_i), .phase_b_i(phase_b_i), .enable_b_i(enable_b_i),
      .torque_i(torque_i), .overcurrent_shutdown_i(ovc_i), .thermal_shutdown_i(tsd_i),
      .thermal_warning_trip_i(warn_i), .motor_supply_restart_i(restart_i), .sw_a_pos_o(a_pos),
      .sw_a_neg_o(a_neg), .sw_b_pos_o(b_pos), .sw_b_neg_o(b_neg), .current_setting_o(cur),
      .regulation_on_o(reg_on), .bias_on_o(bias), .off_time_oscillator_run_o(osc),
      .fault_flag_o(f_d), .fault_flag_oe_n_o(f_oe_n), .thermal_warning_output_o(w_d),
      .thermal_warning_output_oe_n_o(w_oe_n));
   host_pin_model host_u (.clk_i(clk_i), .rstn_i(rstn_i), .low_power_control_i(low_power_control_i),
      .fault_data_i(f_d), .fault_oe_n_i(f_oe_n), .warn_data_i(w_d), .warn_oe_n_i(w_oe_n),
      .fault_pin_o(fault_pin), .warn_pin_o(warn_pin), .quiet_o(quiet));
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic chk_bit(input string what, input logic exp, input logic seen);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected %s expected %b seen %b", what, exp, seen);
      end
   endtask
   task automatic chk_vec(input string what, input logic [3:0] exp, input logic [3:0] seen);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Lets n rising edges pass, then samples on the falling edge
   task automatic settle(input int n);
      repeat (n) @(posedge clk_i);
      @(negedge clk_i);
   endtask
   // Host keeps pins still until the wake-up time is over
   task automatic wake();
      @(posedge clk_i);
      low_power_control_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      for (int i = 0; quiet === 1'b1; i++) begin
         if (i > 500) begin
            fails++;
            report_and_stop();
         end
         @(posedge clk_i);
      end
   endtask
   // Counts cycles with winding A fully off until the negative side turns on
   task automatic flip_a_to_neg();
      cnt = 0;
      both_on = 1'b0;
      @(posedge clk_i);
      phase_a_i <= 1'b0;
      for (int i = 0; a_neg !== 1'b1; i++) begin
         if (i > 60) begin
            fails++;
            report_and_stop();
         end
         @(negedge clk_i);
         if (a_pos === 1'b0 && a_neg === 1'b0) cnt++;
         if (a_pos === 1'b1 && a_neg === 1'b1) both_on = 1'b1;
      end
   endtask
   initial begin
      repeat (6) @(posedge clk_i);
      rstn_i <= 1'b1;
      settle(6);
      chk_vec("switches in standby", 4'h0, sw);
      chk_bit("bias in standby", 1'b0, bias);
      chk_bit("fault pin released", 1'b1, fault_pin);
      wake();
      settle(40);
      chk_bit("bias awake", 1'b1, bias);
      chk_bit("oscillator awake", 1'b1, osc);
      chk_vec("normal switches", 4'h9, sw);
      chk_bit("regulation on", 1'b1, reg_on);
      $display("test wake done");
      for (int t = 0; t < 16; t += 5) begin
         @(posedge clk_i);
         torque_i <= 4'(t);
         settle(2);
         chk_vec("torque passthrough", 4'(t), cur);
      end
      @(posedge clk_i);
      enable_b_i <= 1'b0;
      settle(3);
      chk_vec("winding b disabled", 4'h8, sw);
      @(posedge clk_i);
      enable_b_i <= 1'b1;
      settle(40);
      flip_a_to_neg();
      chk_bit("no shoot-through", 1'b0, both_on);
      chk_bit("off time in range", 1'b1, (cnt >= 13 && cnt <= 27));
      chk_vec("negative side after reversal", 4'h5, sw);
      $display("test normal drive done");
      @(posedge clk_i);
      brake_i <= 1'b1;
      enable_a_i <= 1'b0;
      torque_i <= 4'h3;
      settle(8);
      chk_vec("brake full scale", stepper_ctrl_pkg::TRQ_FULL, cur);
      chk_vec("brake phase low side", 4'h5, sw);
      @(posedge clk_i);
      phase_a_i <= 1'b1;
      settle(40);
      chk_vec("brake phase moved", 4'h9, sw);
      @(posedge clk_i);
      regulation_off_i <= 1'b1;
      settle(8);
      chk_vec("brake unregulated", 4'hF, sw);
      chk_bit("regulation disabled", 1'b0, reg_on);
      @(posedge clk_i);
      regulation_off_i <= 1'b0;
      brake_i <= 1'b0;
      enable_a_i <= 1'b1;
      settle(40);
      chk_vec("brake released", 4'h9, sw);
      $display("test brake done");
      // Detector pulse short on purpose: the latch must outlive it
      @(posedge clk_i);
      ovc_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      ovc_i <= 1'b0;
      settle(8);
      chk_vec("switches after trip", 4'h0, sw);
      chk_bit("fault pin low", 1'b0, fault_pin);
      @(posedge clk_i);
      restart_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      restart_i <= 1'b0;
      settle(40);
      chk_bit("fault released by supply", 1'b1, fault_pin);
      chk_vec("drive after supply", 4'h9, sw);
      @(posedge clk_i);
      tsd_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      tsd_i <= 1'b0;
      settle(8);
      chk_bit("fault pin thermal", 1'b0, fault_pin);
      @(posedge clk_i);
      low_power_control_i <= 1'b0;
      settle(8);
      chk_bit("fault released by standby", 1'b1, fault_pin);
      chk_bit("bias cut", 1'b0, bias);
      chk_bit("oscillator stopped", 1'b0, osc);
      chk_vec("drive stopped", 4'h0, sw);
      wake();
      settle(40);
      chk_vec("latch cleared by standby", 4'h9, sw);
      $display("test fault done");
      @(posedge clk_i);
      warn_i <= 1'b1;
      settle(8);
      chk_bit("warning pin low", 1'b0, warn_pin);
      chk_bit("warning leaves fault", 1'b1, fault_pin);
      @(posedge clk_i);
      warn_i <= 1'b0;
      settle(8);
      chk_bit("warning released", 1'b1, warn_pin);
      $display("test warning done");
      report_and_stop();
   end
endmodule
`default_nettype wire

// File: rtl/phase_dead_timer.sv
// Purpose: Holds one winding's applied phase and blanks it across a reversal
// Assumes: tick_i is a one-cycle enable at the internal oscillator rate
// Notes:   Except on clear_i, the applied phase moves only once the off time has run out
`timescale 1ns/1ps
`default_nettype none
module phase_dead_timer (
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic rstn_i,
   // Control
   input  wire logic tick_i,
   input  wire logic clear_i,
   input  wire logic phase_i,
   // Status
   output logic      busy_o,
   output logic      phase_o
);
   logic                                 seen_reg;
   logic                                 seen_next;
   logic                                 applied_reg;
   logic                                 applied_next;
   logic [stepper_ctrl_pkg::DEAD_W-1:0]  count_reg;
   logic [stepper_ctrl_pkg::DEAD_W-1:0]  count_next;
   logic                                 busy_reg;
   logic                                 busy_next;

   always_comb begin
      seen_next    = seen_reg;
      applied_next = applied_reg;
      count_next   = count_reg;
      if (clear_i) begin
         seen_next    = phase_i;
         applied_next = phase_i;
         count_next   = '0;
      end else if (phase_i != seen_reg) begin
         seen_next  = phase_i;
         count_next = stepper_ctrl_pkg::DEAD_LOAD;
      end else if (count_reg != '0 && tick_i) begin
         count_next = count_reg - 1'b1;
         if (count_reg == 1) begin
            applied_next = seen_reg;
         end
      end
      busy_next = (count_next != '0);
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         seen_reg    <= 1'b0;
         applied_reg <= 1'b0;
         count_reg   <= '0;
         busy_reg    <= 1'b0;
      end else begin
         seen_reg    <= seen_next;
         applied_reg <= applied_next;
         count_reg   <= count_next;
         busy_reg    <= busy_next;
      end
   end

   assign busy_o  = busy_reg;
   assign phase_o = applied_reg;
endmodule
`default_nettype wire

// File: rtl/stepper_brake_standby_fault.sv
// Purpose: Brake, standby, fault latch, warning flag and phase off time of a
//          two-phase unipolar stepper output stage
// Assumes: Phase, enable and torque come from the storage register on clk_i;
//          pins and analog detector trips are asynchronous
// Notes:   Detector inputs arrive already blanked; torque code goes to the DAC
//
// Function
// - In brake with regulation on, each winding is driven at full current, polarity set by its phase.
// - A phase change during brake moves regulation to the opposite output side.
// - In brake, outside standby and shutdown, the current setting is full scale whatever the torque code says.
// - In brake with regulation off, all four output switches are on together.
// - With brake low the outputs follow the stored phase, enable and torque.
// - Standby low cuts internal bias; standby high is normal operation.
// - Standby low clears the latched over-current and thermal shutdown status.
// - The open-drain fault flag is pulled low once a shutdown is detected, released otherwise.
// - The fault flag is released when standby goes low or the motor supply comes back.
// - Outside standby, the open-drain warning flag is pulled low while the temperature detector trips.
// - The warning flag does not latch and releases as soon as the detector clears.
// - A phase reversal inserts an off time of about three oscillator cycles, four at most.
// - Regulation is disabled while the threshold input is tied to the logic supply.
// - A shutdown detection turns all switches off and latches until cleared.
// - Phase high drives the positive-side output, phase low the negative side.
// - Standby also stops the internal oscillator and all motor drive.
`timescale 1ns/1ps
`default_nettype none
module stepper_brake_standby_fault (
   // Clock and reset
   input  wire logic                                clk_i,
   input  wire logic                                rstn_i,
   // Control pins
   input  wire logic                                brake_i,
   input  wire logic                                low_power_control_i,
   input  wire logic                                regulation_off_i,
   // Stored settings
   input  wire logic                                phase_a_i,
   input  wire logic                                enable_a_i,
   input  wire logic                                phase_b_i,
   input  wire logic                                enable_b_i,
   input  wire logic [stepper_ctrl_pkg::TRQ_W-1:0]  torque_i,
   // Detectors and supply
   input  wire logic                                overcurrent_shutdown_i,
   input  wire logic                                thermal_shutdown_i,
   input  wire logic                                thermal_warning_trip_i,
   input  wire logic                                motor_supply_restart_i,
   // Output switches
   output logic                                     sw_a_pos_o,
   output logic                                     sw_a_neg_o,
   output logic                                     sw_b_pos_o,
   output logic                                     sw_b_neg_o,
   output logic [stepper_ctrl_pkg::TRQ_W-1:0]       current_setting_o,
   output logic                                     regulation_on_o,
   // Power state
   output logic                                     bias_on_o,
   output logic                                     off_time_oscillator_run_o,
   // Open-drain flags
   output logic                                     fault_flag_o,
   output logic                                     fault_flag_oe_n_o,
   output logic                                     thermal_warning_output_o,
   output logic                                     thermal_warning_output_oe_n_o
);
   // Pin synchroniser
   logic [stepper_ctrl_pkg::SYNC_W-1:0]  meta_reg;
   logic [stepper_ctrl_pkg::SYNC_W-1:0]  sync_reg;
   logic                                 brake_s;
   logic                                 low_power_control_s;
   logic                                 reg_on;
   logic                                 det_s;

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         meta_reg <= stepper_ctrl_pkg::SYNC_RST;
         sync_reg <= stepper_ctrl_pkg::SYNC_RST;
      end else begin
         meta_reg <= {motor_supply_restart_i, thermal_warning_trip_i, thermal_shutdown_i,
                      overcurrent_shutdown_i, regulation_off_i, low_power_control_i, brake_i};
         sync_reg <= meta_reg;
      end
   end

   assign brake_s = sync_reg[stepper_ctrl_pkg::S_BRAKE];
   assign low_power_control_s  = sync_reg[stepper_ctrl_pkg::S_LOW_POWER_CONTROL];
   assign reg_on  = !sync_reg[stepper_ctrl_pkg::S_REG_OFF];
   assign det_s   = sync_reg[stepper_ctrl_pkg::S_OVC] | sync_reg[stepper_ctrl_pkg::S_TSD];

   // Internal oscillator as a fractional enable
   logic [stepper_ctrl_pkg::ACC_W-1:0]  acc_reg;
   logic [stepper_ctrl_pkg::ACC_W-1:0]  acc_next;
   logic                                tick_reg;
   logic                                tick_next;

   always_comb begin
      acc_next  = acc_reg + stepper_ctrl_pkg::OSC_STEP_V;
      tick_next = 1'b0;
      if (!low_power_control_s) begin
         acc_next = '0;
      end else if (acc_next >= stepper_ctrl_pkg::OSC_MOD_V) begin
         acc_next  = acc_next - stepper_ctrl_pkg::OSC_MOD_V;
         tick_next = 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         acc_reg  <= '0;
         tick_reg <= 1'b0;
      end else begin
         acc_reg  <= acc_next;
         tick_reg <= tick_next;
      end
   end

   // Per-winding off time at reversal
   logic  busy_a;
   logic  busy_b;
   logic  ph_a;
   logic  ph_b;

   phase_dead_timer dead_a (
      .clk_i   (clk_i),
      .rstn_i  (rstn_i),
      .tick_i  (tick_reg),
      .clear_i (!low_power_control_s),
      .phase_i (phase_a_i),
      .busy_o  (busy_a),
      .phase_o (ph_a)
   );

   phase_dead_timer dead_b (
      .clk_i   (clk_i),
      .rstn_i  (rstn_i),
      .tick_i  (tick_reg),
      .clear_i (!low_power_control_s),
      .phase_i (phase_b_i),
      .busy_o  (busy_b),
      .phase_o (ph_b)
   );

   // Winding switch pair {pos, neg}
   function automatic logic [1:0] drive_pair(input logic en, input logic ph, input logic busy);
      logic [1:0] pair;
      pair = 2'h0;
      if (en && !busy) begin
         pair = {ph, !ph};
      end
      return pair;
   endfunction

   // Fault latch and output stage
   logic                                fault_reg;
   logic                                fault_next;
   logic [3:0]                          sw_reg;
   logic [3:0]                          sw_next;
   logic [stepper_ctrl_pkg::TRQ_W-1:0]  cur_reg;
   logic [stepper_ctrl_pkg::TRQ_W-1:0]  cur_next;
   logic                                regon_reg;
   logic                                regon_next;
   logic                                bias_reg;
   logic                                bias_next;
   logic                                osc_reg;
   logic                                osc_next;
   logic                                fault_oe_n_reg;
   logic                                fault_oe_n_next;
   logic                                warn_oe_n_reg;
   logic                                warn_oe_n_next;
   logic                                od_low_reg;

   always_comb begin
      // Detection latches; set wins over a supply restart
      fault_next = low_power_control_s && (det_s || (fault_reg && !sync_reg[stepper_ctrl_pkg::S_POR]));
      // Flag pulled low from the latch
      fault_oe_n_next = !fault_next;
      // No latching, releases with the detector
      warn_oe_n_next = !(low_power_control_s && sync_reg[stepper_ctrl_pkg::S_WARN]);
      bias_next  = low_power_control_s;
      osc_next   = low_power_control_s;
      regon_next = low_power_control_s && !fault_reg && reg_on;
      cur_next   = torque_i;
      sw_next    = 4'h0;
      if (!low_power_control_s || fault_reg) begin
         sw_next = 4'h0;
      end else if (brake_s) begin
         cur_next = stepper_ctrl_pkg::TRQ_FULL;
         if (!reg_on) begin
            sw_next = 4'hF;
         end else begin
            sw_next = {drive_pair(1'b1, ph_b, busy_b), drive_pair(1'b1, ph_a, busy_a)};
         end
      end else begin
         sw_next = {drive_pair(enable_b_i, ph_b, busy_b), drive_pair(enable_a_i, ph_a, busy_a)};
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         fault_reg      <= 1'b0;
         sw_reg         <= 4'h0;
         cur_reg        <= stepper_ctrl_pkg::TRQ_RST;
         regon_reg      <= 1'b0;
         bias_reg       <= 1'b0;
         osc_reg        <= 1'b0;
         fault_oe_n_reg <= 1'b1;
         warn_oe_n_reg  <= 1'b1;
         od_low_reg     <= 1'b0;
      end else begin
         fault_reg      <= fault_next;
         sw_reg         <= sw_next;
         cur_reg        <= cur_next;
         regon_reg      <= regon_next;
         bias_reg       <= bias_next;
         osc_reg        <= osc_next;
         fault_oe_n_reg <= fault_oe_n_next;
         warn_oe_n_reg  <= warn_oe_n_next;
         od_low_reg     <= 1'b0;
      end
   end

   // Open-drain pins only ever pull low
   assign sw_a_pos_o                    = sw_reg[1];
   assign sw_a_neg_o                    = sw_reg[0];
   assign sw_b_pos_o                    = sw_reg[3];
   assign sw_b_neg_o                    = sw_reg[2];
   assign current_setting_o             = cur_reg;
   assign regulation_on_o               = regon_reg;
   assign bias_on_o                     = bias_reg;
   assign off_time_oscillator_run_o     = osc_reg;
   assign fault_flag_o                  = od_low_reg;
   assign fault_flag_oe_n_o             = fault_oe_n_reg;
   assign thermal_warning_output_o      = od_low_reg;
   assign thermal_warning_output_oe_n_o = warn_oe_n_reg;

   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);

   // Off states of each winding, shared by several checks
   sequence a_off_s;
      !sw_a_pos_o && !sw_a_neg_o;
   endsequence

   sequence b_off_s;
      !sw_b_pos_o && !sw_b_neg_o;
   endsequence

   brake_polarity_a: assert property (low_power_control_s && brake_s && reg_on && !fault_reg && !busy_a
      |=> sw_a_pos_o == $past(ph_a) && sw_a_neg_o == !$past(ph_a))
      else $error("brake polarity wrong");
   brake_polarity_b_a: assert property (low_power_control_s && brake_s && reg_on && !fault_reg && !busy_b
      |=> sw_b_pos_o == $past(ph_b) && sw_b_neg_o == !$past(ph_b))
      else $error("brake polarity wrong on winding b");
   brake_full_a: assert property (low_power_control_s && brake_s && !fault_reg
      |=> current_setting_o == stepper_ctrl_pkg::TRQ_FULL)
      else $error("brake current not full");
   brake_all_on_a: assert property (low_power_control_s && brake_s && !reg_on && !fault_reg
      |=> sw_a_pos_o && sw_a_neg_o && sw_b_pos_o && sw_b_neg_o)
      else $error("brake did not close all switches");
   normal_enable_a: assert property (low_power_control_s && !brake_s && !enable_a_i |=> a_off_s)
      else $error("disabled winding driven");
   normal_enable_b_a: assert property (low_power_control_s && !brake_s && !enable_b_i |=> b_off_s)
      else $error("disabled winding b driven");
   torque_pass_a: assert property (!brake_s |=> current_setting_o == $past(torque_i))
      else $error("torque code not passed through");
   standby_off_a: assert property (!low_power_control_s
      |=> (!bias_on_o && !off_time_oscillator_run_o) and a_off_s and b_off_s)
      else $error("standby left drive on");
   standby_clear_a: assert property (!low_power_control_s |=> !fault_reg ##1 fault_flag_oe_n_o)
      else $error("standby did not clear fault");
   fault_flag_a: assert property (low_power_control_s && det_s |=> fault_reg ##1 !fault_flag_oe_n_o)
      else $error("fault flag not pulled low");
   supply_clear_a: assert property (low_power_control_s && !det_s && sync_reg[stepper_ctrl_pkg::S_POR]
      |=> fault_flag_oe_n_o)
      else $error("supply restart did not release fault");
   warn_pull_a: assert property (low_power_control_s && sync_reg[stepper_ctrl_pkg::S_WARN]
      |=> !thermal_warning_output_oe_n_o)
      else $error("warning flag not pulled low");
   fault_cut_a: assert property (fault_reg |=> !sw_a_pos_o && !sw_a_neg_o && !sw_b_pos_o && !sw_b_neg_o)
      else $error("switches on after shutdown");
   fault_hold_a: assert property (low_power_control_s && fault_reg && !sync_reg[stepper_ctrl_pkg::S_POR] |=> fault_reg)
      else $error("fault latch dropped");
   warn_release_a: assert property (!sync_reg[stepper_ctrl_pkg::S_WARN] |=> thermal_warning_output_oe_n_o)
      else $error("warning flag latched");
   regulation_off_a: assert property (sync_reg[stepper_ctrl_pkg::S_REG_OFF] |=> !regulation_on_o)
      else $error("regulation left on");
   normal_side_a: assert property (low_power_control_s && !brake_s && !fault_reg && enable_a_i && !busy_a
      |=> sw_a_pos_o == $past(ph_a) && sw_a_neg_o == !$past(ph_a))
      else $error("winding side does not follow phase");
   osc_stop_a: assert property (!low_power_control_s |=> !tick_reg && acc_reg == '0)
      else $error("oscillator ticking in standby");
   reversal_gap_a: assert property (low_power_control_s && !brake_s && !fault_reg && phase_a_i != $past(phase_a_i)
      |=> ##1 a_off_s [*8])
      else $error("no off time at reversal");
endmodule
`default_nettype wire

// File: rtl/stepper_ctrl_pkg.sv
// Purpose: Shared constants of the stepper brake, standby and fault logic
// Assumes: 40 MHz system clock
// Notes:   Phase-reversal off time is counted in ticks of the internal oscillator
package stepper_ctrl_pkg;
   // System clock and the internal system oscillator it models
   localparam int unsigned CLK_HZ                     = 40_000_000;
   localparam int unsigned SYSTEM_OSCILLATOR_FREQUENCY = 6_400_000;
   // Fractional divider: add OSC_STEP each cycle, wrap at OSC_MOD
   localparam int unsigned OSC_GRAIN = 100_000;
   localparam int unsigned OSC_MOD   = CLK_HZ / OSC_GRAIN;
   localparam int unsigned OSC_STEP  = SYSTEM_OSCILLATOR_FREQUENCY / OSC_GRAIN;
   localparam int unsigned ACC_W     = 9;
   localparam logic [ACC_W-1:0] OSC_MOD_V  = ACC_W'(OSC_MOD);
   localparam logic [ACC_W-1:0] OSC_STEP_V = ACC_W'(OSC_STEP);
   // Off time at phase reversal, in oscillator ticks
   localparam int unsigned DEAD_OSC_CLK  = 3;
   localparam int unsigned DEAD_SYNC_CLK = 1;
   localparam int unsigned DEAD_W        = 3;
   localparam logic [DEAD_W-1:0] DEAD_LOAD = DEAD_W'(DEAD_OSC_CLK + DEAD_SYNC_CLK);
   // Torque code and its full-scale value
   localparam int unsigned TRQ_W    = 4;
   localparam logic [TRQ_W-1:0] TRQ_FULL = 4'hF;
   // Pin synchroniser lanes
   localparam int unsigned SYNC_W     = 7;
   localparam int unsigned S_BRAKE    = 0;
   localparam int unsigned S_LOW_POWER_CONTROL     = 1;
   localparam int unsigned S_REG_OFF  = 2;
   localparam int unsigned S_OVC      = 3;
   localparam int unsigned S_TSD      = 4;
   localparam int unsigned S_WARN     = 5;
   localparam int unsigned S_POR      = 6;
   // Reset values
   localparam logic [SYNC_W-1:0] SYNC_RST = 7'h00;
   localparam logic [TRQ_W-1:0]  TRQ_RST  = 4'h0;
endpackage
